// [sac_core_model.sv]
`timescale 1ns/1ps
module sac_core_model (
  // Clock
  input wire logic hclk,
  // Converter side
  input wire logic [5:0] channel_select,
  input wire logic sample_hold,
  input wire logic converting,
  output logic [9:0] core_result
);
  logic [5:0] held_r;
  // ----------------------------------------
  // Sample and code
  // ----------------------------------------
  always_ff @(posedge hclk)
  begin
    if (sample_hold)
      held_r <= channel_select;
  end
  // Code inverted outside conversions so a stray capture shows
  assign core_result = converting ? {4'h9, held_r} : ~{4'h9, held_r};
endmodule : sac_core_model

// [sac_ctrl.sv]
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_ctrl (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Trigger sources
  input wire logic [7:0] trig_i,
  // Analog side
  input wire logic [9:0] core_result,
  output logic analog_enable,
  output logic [1:0] reference_select,
  output logic [5:0] channel_select,
  output logic gain_20x,
  output logic differential,
  output logic temp_sensor,
  output logic conv_clk,
  output logic sample_hold,
  output logic converting
);

  sac_pkg::sac_state_type s;
  sac_pkg::sac_state_type n;

  logic accept;
  logic trig_lvl;
  logic edge_hit;
  logic htick;
  logic rise;
  logic done;
  logic self_trig;
  logic [5:0] hnext;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic flag_clr;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Half period of the converter clock, in CPU cycles
  // Codes 0 and 1 both divide by 2, so the ratio tops out at 128
  function automatic logic [6:0] half_period(input logic [2:0] ps);
    half_period = (ps == 3'h0) ? 7'h01 : 7'h01 << (ps - 3'h1);
  endfunction : half_period

  function automatic logic [7:0] lo_byte(input logic [9:0] r, input logic la);
    lo_byte = la ? {r[1:0], 6'h00} : r[7:0];
  endfunction : lo_byte

  function automatic logic [7:0] hi_byte(input logic [9:0] r, input logic la);
    hi_byte = la ? r[9:2] : {6'h00, r[9:8]};
  endfunction : hi_byte

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = s;
    n.sh = 1'b0;
    accept = hsel && htrans[1] && hready;
    res_lo = lo_byte(s.result, s.left_adj);
    res_hi = hi_byte(s.result, s.left_adj);
    trig_lvl = trig_i[s.tsrc];
    self_trig = s.tsrc == `SAC_TSRC_SELF;
    // Rising edge only; a level held high never retriggers
    edge_hit = s.enable && s.auto_en && !self_trig && trig_lvl && !s.trig_prev;
    n.trig_prev = trig_lvl;
    htick = s.enable && (s.pre == half_period(s.ps) - 7'h01);
    rise = htick && !s.cclk;
    hnext = s.hcnt + 6'h01;
    done = 1'b0;
    flag_clr = s.wr_pend && (s.a_idx == `SAC_IDX_CTRL_A) && hwdata[`SAC_CA_FLAG];

    // Prescaler
    if (!s.enable)
    begin
      n.pre = 7'h00;
      n.cclk = 1'b0;
    end
    else if (edge_hit && s.phase != sac_pkg::PH_CONV)
    begin
      n.pre = 7'h00;
      n.cclk = 1'b0;
    end
    else if (htick)
    begin
      n.pre = 7'h00;
      n.cclk = !s.cclk;
    end
    else
    begin
      n.pre = s.pre + 7'h01;
    end

    // Conversion sequencer
    unique case (s.phase)
      sac_pkg::PH_IDLE:
      begin
        if (edge_hit)
        begin
          n.phase = sac_pkg::PH_CONV;
          n.start = 1'b1;
          n.hcnt = 6'h00;
          n.len_h = s.first ? 6'(2 * `SAC_FIRST_CYC) : `SAC_AUTO_HALF;
          n.sh_h = s.first ? `SAC_SH_FIRST_HALF : `SAC_SH_AUTO_HALF;
          n.first = 1'b0;
        end
        else if (s.start && s.enable)
        begin
          n.phase = sac_pkg::PH_WAIT;
        end
      end
      sac_pkg::PH_WAIT:
      begin
        if (rise)
        begin
          n.phase = sac_pkg::PH_CONV;
          n.hcnt = 6'h00;
          n.len_h = s.first ? 6'(2 * `SAC_FIRST_CYC) : 6'(2 * `SAC_NORM_CYC);
          n.sh_h = s.first ? `SAC_SH_FIRST_HALF : `SAC_SH_NORM_HALF;
          n.first = 1'b0;
        end
      end
      sac_pkg::PH_CONV:
      begin
        // Edges here are dropped, not queued
        if (htick)
        begin
          n.hcnt = hnext;
          n.sh = hnext == s.sh_h;
          if (hnext == s.len_h)
          begin
            done = 1'b1;
            if (!s.lock)
            begin
              n.result = core_result;
            end
            if (s.auto_en && self_trig)
            begin
              n.phase = sac_pkg::PH_WAIT;
            end
            else
            begin
              n.phase = sac_pkg::PH_IDLE;
              n.start = 1'b0;
            end
          end
        end
      end
      default:
      begin
        n.phase = sac_pkg::PH_IDLE;
      end
    endcase

    // Set wins over a same-cycle software clear
    n.flag = (s.flag && !flag_clr) || done;

    // Selection buffer: follows the register while enabled, except mid-conversion
    if (s.enable && (s.phase != sac_pkg::PH_CONV || s.hcnt + 6'h02 >= s.len_h))
    begin
      n.buf_ref = s.ref_sel;
      n.buf_chan = s.chan_sel;
    end
    n.temp = n.buf_chan == `SAC_TEMP_CODE;
    n.diff = !n.temp && (n.buf_chan > `SAC_SE_MAX);
    n.gain20 = n.diff && n.buf_chan[0];

    // Register write, data phase
    if (s.wr_pend)
    begin
      unique case (s.a_idx)
        `SAC_IDX_CTRL_A:
        begin
          n.enable = hwdata[`SAC_CA_EN];
          n.auto_en = hwdata[`SAC_CA_AUTO];
          n.ps = hwdata[2:0];
          if (hwdata[`SAC_CA_START] && hwdata[`SAC_CA_EN])
          begin
            n.start = 1'b1;
          end
        end
        `SAC_IDX_CTRL_B:
        begin
          n.left_adj = hwdata[`SAC_CB_LADJ];
          n.tsrc = hwdata[2:0];
        end
        `SAC_IDX_INSEL:
        begin
          n.ref_sel = hwdata[`SAC_IS_REF +: 2];
          n.chan_sel = hwdata[5:0];
        end
        default:
        begin
          n.wr_pend = 1'b0;
        end
      endcase
    end

    // Disabling aborts and rearms the long first conversion
    if (!n.enable)
    begin
      n.phase = sac_pkg::PH_IDLE;
      n.start = 1'b0;
      n.first = 1'b1;
      n.hcnt = 6'h00;
      n.pre = 7'h00;
      n.cclk = 1'b0;
      n.sh = 1'b0;
    end

    // Register read, one wait state so data is always fresh
    if (s.rd_pend)
    begin
      n.rd_pend = 1'b0;
      n.hready = 1'b1;
      unique case (s.a_idx)
        `SAC_IDX_CTRL_A: n.hrdata = {24'h000000, s.enable, s.start, s.auto_en, s.flag,
                                     1'b0, s.ps};
        `SAC_IDX_CTRL_B: n.hrdata = {27'h0000000, s.left_adj, 1'b0, s.tsrc};
        `SAC_IDX_INSEL: n.hrdata = {24'h000000, s.ref_sel, s.chan_sel};
        `SAC_IDX_RES_LO: n.hrdata = {24'h000000, res_lo};
        `SAC_IDX_RES_HI: n.hrdata = {24'h000000, res_hi};
        default: n.hrdata = 32'h00000000;
      endcase
      if (s.a_idx == `SAC_IDX_RES_LO)
      begin
        n.lock = 1'b1;
      end
      else if (s.a_idx == `SAC_IDX_RES_HI)
      begin
        n.lock = 1'b0;
      end
    end

    // Address phase
    n.wr_pend = accept && hwrite;
    if (accept)
    begin
      n.a_idx = haddr[4:2];
      if (!hwrite)
      begin
        n.rd_pend = 1'b1;
        n.hready = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.first <= 1'b1;
      s.hready <= 1'b1;
      s.phase <= sac_pkg::PH_IDLE;
    end
    else if (ce)
    begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hreadyout = s.hready;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign analog_enable = s.enable;
  assign reference_select = s.buf_ref;
  assign channel_select = s.buf_chan;
  assign gain_20x = s.gain20;
  assign differential = s.diff;
  assign temp_sensor = s.temp;
  assign conv_clk = s.cclk;
  assign sample_hold = s.sh;
  // Only the conversion code has its top bit set
  assign converting = s.phase[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_start_reads_one: assert property (@(posedge hclk) disable iff (!hresetn)
    s.phase == sac_pkg::PH_CONV |-> s.start)
    else $error("start bit low during conversion");

  a_done_clears_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && done && n.phase == sac_pkg::PH_IDLE) |=> (!s.start && s.flag))
    else $error("completion did not clear start and set flag");

  a_lock_keeps_result: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && done && s.lock) |=> $stable(s.result))
    else $error("locked result was overwritten");

  a_flag_when_lost: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && done && s.lock) |=> s.flag)
    else $error("flag missing for discarded result");

  a_prescaler_held: assert property (@(posedge hclk) disable iff (!hresetn)
    !s.enable |-> (s.pre == 7'h00 && !s.cclk))
    else $error("prescaler ran while disabled");

  a_buffer_locked: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.phase == sac_pkg::PH_CONV && s.hcnt + 6'h02 < s.len_h)
      |=> $stable(s.buf_chan) && $stable(s.buf_ref))
    else $error("selection changed mid-conversion");

  a_disabled_no_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !s.enable) |=> $stable(s.buf_chan))
    else $error("selection applied while disabled");

  a_edge_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.phase == sac_pkg::PH_CONV && edge_hit && !done && n.enable)
      |=> (s.phase == sac_pkg::PH_CONV && s.hcnt == $past(s.hcnt) + {5'h00, $past(htick)}))
    else $error("trigger edge disturbed running conversion");

  a_normal_length: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.phase == sac_pkg::PH_WAIT && rise && !s.first && n.enable)
      |=> s.len_h == 6'(2 * `SAC_NORM_CYC))
    else $error("normal conversion not 13 cycles");

  a_sample_instant: assert property (@(posedge hclk) disable iff (!hresetn)
    s.sh |-> s.hcnt == ((s.len_h == `SAC_AUTO_HALF) ? `SAC_SH_AUTO_HALF :
      (s.len_h == 6'(2 * `SAC_NORM_CYC)) ? `SAC_SH_NORM_HALF : `SAC_SH_FIRST_HALF))
    else $error("sample-and-hold at wrong instant");

  a_auto_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.phase == sac_pkg::PH_IDLE && edge_hit && !s.first && n.enable)
      |=> s.sh_h == `SAC_SH_AUTO_HALF)
    else $error("auto sample not two cycles after edge");

endmodule : sac_ctrl

// [sac_map.svh]
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ----------------------------------------
// Register word indices (haddr[4:2])
// ----------------------------------------
`define SAC_IDX_CTRL_A 3'h0
`define SAC_IDX_CTRL_B 3'h1
`define SAC_IDX_INSEL 3'h2
`define SAC_IDX_RES_LO 3'h3
`define SAC_IDX_RES_HI 3'h4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SAC_CA_EN 7
`define SAC_CA_START 6
`define SAC_CA_AUTO 5
`define SAC_CA_FLAG 4
`define SAC_CB_LADJ 4
`define SAC_IS_REF 6
// ----------------------------------------
// Conversion timing, in converter clock cycles and half cycles
// ----------------------------------------
`define SAC_NORM_CYC 13
`define SAC_FIRST_CYC 25
`define SAC_AUTO_HALF 6'h1b
`define SAC_SH_NORM_HALF 6'h03
`define SAC_SH_FIRST_HALF 6'h1b
`define SAC_SH_AUTO_HALF 6'h04
// ----------------------------------------
// Channel and trigger source codes
// ----------------------------------------
`define SAC_TEMP_CODE 6'h22
`define SAC_SE_MAX 6'h07
`define SAC_TSRC_SELF 3'h0
`endif

// [sac_pkg.sv]
package sac_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_CONV = 2'b10
  } sac_phase_type;

  typedef struct packed {
    logic enable;
    logic start;
    logic auto_en;
    logic flag;
    logic [2:0] ps;
    logic left_adj;
    logic [2:0] tsrc;
    logic [1:0] ref_sel;
    logic [5:0] chan_sel;
    logic [1:0] buf_ref;
    logic [5:0] buf_chan;
    logic [9:0] result;
    logic lock;
    logic first;
    sac_phase_type phase;
    logic [5:0] hcnt;
    logic [5:0] len_h;
    logic [5:0] sh_h;
    logic [6:0] pre;
    logic cclk;
    logic trig_prev;
    logic sh;
    logic gain20;
    logic diff;
    logic temp;
    logic wr_pend;
    logic rd_pend;
    logic [2:0] a_idx;
    logic hready;
    logic [31:0] hrdata;
  } sac_state_type;
endpackage : sac_pkg

// [sar_adc_conversion_control_tb_top.sv]
`timescale 1ns/1ps
module sar_adc_conversion_control_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] trig_i = 8'h00;
  logic hreadyout, hresp, analog_enable, gain_20x, differential, temp_sensor;
  logic conv_clk, sample_hold, converting;
  logic [31:0] hrdata, rd;
  logic [1:0] reference_select;
  logic [5:0] channel_select;
  logic [9:0] core_result;
  int n_fail = 0;
  int n_tests = 0;
  int n, sh;
  int cyc = 0;
  // Address, write data, read back
  logic [95:0] rows [7] = '{{32'h04, 32'hff, 32'h17}, {32'h08, 32'h1ff, 32'hff},
    {32'h14, 32'hff, 32'h0}, {32'h0c, 32'hff, 32'h0}, {32'h00, 32'h47, 32'h07},
    {32'h00, 32'h00, 32'h0}, {32'h04, 32'h00, 32'h0}};
  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  sac_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_i(trig_i),
    .core_result(core_result), .analog_enable(analog_enable),
    .reference_select(reference_select), .channel_select(channel_select),
    .gain_20x(gain_20x), .differential(differential), .temp_sensor(temp_sensor),
    .conv_clk(conv_clk), .sample_hold(sample_hold), .converting(converting));
  sac_core_model i_core (.hclk(hclk), .channel_select(channel_select),
    .sample_hold(sample_hold), .converting(converting), .core_result(core_result));
  // ----------------------------------------
  // Clock, timeout, tasks
  // ----------------------------------------
  initial
  begin
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Ready is looked at before the edge, so no race with its update
  task wait_rdy;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask : wait_rdy
  task bus(input logic [31:0] a, input logic [31:0] d, input logic w);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask : bus
  task bw(input logic [31:0] a, input logic [31:0] d);
    bus(a, d, 1'b1);
  endtask : bw
  task rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask : rchk
  // Length of the next conversion and where its sample falls
  task conv(input int lim);
    int w;
    n = 0;
    sh = -1;
    w = 0;
    do
    begin
      @(negedge hclk);
      w++;
    end
    while (converting !== 1'b1 && w < lim);
    while (converting === 1'b1)
    begin
      if (sample_hold === 1'b1)
        sh = n;
      n++;
      @(negedge hclk);
    end
  endtask : conv
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge hclk);
    chk(32'({hreadyout, conv_clk}), 32'h2);
    chk(hrdata, 32'h0);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rchk(i * 4, 32'h0);
    foreach (rows[i])
    begin
      bw(rows[i][95:64], rows[i][63:32]);
      rchk(rows[i][95:64], rows[i][31:0]);
    end
    rchk(32'h10, 32'h00);
    $display("end registers");
    bw(32'h08, 32'h62);
    repeat (2) @(negedge hclk);
    chk(32'(channel_select), 32'h00);
    bw(32'h00, 32'h80);
    repeat (4) @(posedge hclk);
    chk(32'({analog_enable, reference_select, temp_sensor, differential}), 32'h16);
    chk(32'(channel_select), 32'h22);
    bw(32'h08, 32'h09);
    repeat (2) @(negedge hclk);
    chk(32'({differential, gain_20x, temp_sensor}), 32'h6);
    bw(32'h08, 32'h03);
    bw(32'h00, 32'hc0);
    fork
      conv(400);
      begin
        repeat (10) @(posedge hclk);
        rchk(32'h00, 32'hc0);
      end
    join
    chk(n, 50);
    chk(sh, 27);
    rchk(32'h00, 32'h90);
    rchk(32'h0c, 32'h43);
    rchk(32'h10, 32'h02);
    bw(32'h00, 32'hd0);
    conv(400);
    chk(n, 26);
    chk(sh, 3);
    $display("end single");
    bw(32'h04, 32'h10);
    rchk(32'h0c, 32'hc0);
    bw(32'h08, 32'h05);
    bw(32'h00, 32'hd0);
    conv(400);
    rchk(32'h00, 32'h90);
    rchk(32'h10, 32'h90);
    bw(32'h00, 32'hd0);
    fork
      conv(400);
      begin
        repeat (10) @(posedge hclk);
        bw(32'h08, 32'h07);
        repeat (2) @(negedge hclk);
        chk(32'(channel_select), 32'h05);
      end
    join
    rchk(32'h0c, 32'h40);
    rchk(32'h10, 32'h91);
    $display("end lock");
    bw(32'h04, 32'h01);
    bw(32'h00, 32'hb0);
    fork
      conv(400);
      begin
        repeat (3) @(posedge hclk);
        trig_i <= 8'h02;
        repeat (12) @(posedge hclk);
        trig_i <= 8'h00;
        @(posedge hclk);
        trig_i <= 8'h02;
      end
    join
    chk(n, 27);
    chk(sh, 4);
    conv(100);
    chk(n, 0);
    @(posedge hclk);
    trig_i <= 8'h00;
    $display("end trigger");
    bw(32'h04, 32'h00);
    bw(32'h00, 32'he0);
    conv(400);
    chk(n, 26);
    conv(20);
    chk(n, 26);
    rchk(32'h00, 32'hf0);
    bw(32'h00, 32'h00);
    repeat (3) @(posedge hclk);
    repeat (8)
    begin
      @(negedge hclk);
      chk(32'({conv_clk, converting, hresp}), 32'h0);
    end
    rchk(32'h00, 32'h10);
    $display("end free run");
    // Slowest ratio keeps the converter clock under 1 MHz
    bw(32'h00, 32'h87);
    @(posedge conv_clk);
    n = 0;
    @(negedge hclk);
    while (conv_clk === 1'b1)
    begin
      n++;
      @(negedge hclk);
    end
    chk(n, 64);
    $display("end prescaler");
    give_verdict;
  end
endmodule : sar_adc_conversion_control_tb_top
